// *** pkg/e3rx_pkg.sv ***
// Purpose: constants and types for the receive E3 framer control/status bank
// Assumes: one 200 MHz clock, 16-bit register port at byte offsets
// Notes: all offsets, fields, resets and timing counts are named here once
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package e3rx_pkg;

	// ------------------------------------------------------------------------
	// register offsets (byte addresses on the port)
	// ------------------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h20;
	localparam logic [7:0] OFS_LIVE_STATUS = 8'h24;
	localparam logic [7:0] OFS_COUNT_STATUS = 8'h26;
	localparam logic [7:0] OFS_CHANGE_LATCHED = 8'h28;
	localparam logic [7:0] OFS_ERROR_LATCHED = 8'h2a;
	localparam logic [7:0] OFS_CHANGE_IRQ_EN = 8'h2c;
	localparam logic [7:0] OFS_ERROR_IRQ_EN = 8'h2e;
	localparam logic [7:0] OFS_ERR_COUNT = 8'h34;

	// ------------------------------------------------------------------------
	// reset values and writable masks
	// ------------------------------------------------------------------------
	localparam logic [15:0] RST_CONTROL = 16'h0000;
	localparam logic [15:0] RST_IRQ_EN = 16'h0000;
	localparam logic [15:0] RST_LATCHED = 16'h0000;
	localparam logic [15:0] MASK_CONTROL = 16'h3fff;
	localparam logic [15:0] MASK_CHANGE = 16'h01ff;
	localparam logic [15:0] MASK_ERROR = 16'h0101;

	// ------------------------------------------------------------------------
	// field positions in status and error registers
	// ------------------------------------------------------------------------
	localparam int BIT_ALIGN_CHANGE = 5;
	localparam int BIT_FRAMING_ERR = 8;
	localparam int BIT_COUNT_RISE = 0;

	// ------------------------------------------------------------------------
	// error count types and integration codes
	// ------------------------------------------------------------------------
	localparam logic [1:0] CNT_OOF_EVENTS = 2'h0;
	localparam logic [1:0] CNT_FAS_BITS = 2'h1;
	localparam logic [1:0] CNT_FAS_WORDS = 2'h2;
	localparam logic [1:0] INTEG_3MS = 2'h0;
	localparam logic [1:0] INTEG_2MS = 2'h1;
	localparam logic [1:0] INTEG_1MS = 2'h2;
	localparam logic [1:0] INTEG_NONE = 2'h3;
	localparam logic [1:0] TX_ALARM_AUTO = 2'h0;
	localparam logic [3:0] FAS_MAX_BIT_ERRS = 4'ha;

	// ------------------------------------------------------------------------
	// timing: integration times in ns and derived cycle counts
	// ------------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned INTEG_3MS_NS = 3000000;
	localparam int unsigned INTEG_2MS_NS = 2000000;
	localparam int unsigned INTEG_1MS_NS = 1000000;
	localparam int unsigned INTEG_3MS_CYC = (INTEG_3MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INTEG_2MS_CYC = (INTEG_2MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INTEG_1MS_CYC = (INTEG_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INTEG_CNT_W = 20;

	// ------------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] reserved;
		logic alarm_link_source_sel;
		logic manual_downstream_alarm_insert;
		logic auto_downstream_alarm_disable;
		logic error_count_control;
		logic [1:0] frame_err_count_type;
		logic remote_alarm_on_frame_loss_en;
		logic remote_alarm_on_signal_loss_dis;
		logic remote_alarm_on_misframe_dis;
		logic remote_alarm_on_ones_alarm_dis;
		logic overhead_masking_disable;
		logic [1:0] frame_loss_integration_sel;
		logic force_realign;
	} e3rx_ctrl_s;

	// framer conditions, all on sys_clk
	typedef struct packed {
		logic unframed_all_ones;
		logic remote_alarm;
		logic ones_alarm;
		logic misframe;
		logic alarm_bit;
		logic national_bit;
		logic fas_check;
		logic [3:0] fas_bit_errs;
		logic align_load;
		logic align_differs;
		logic overhead_pos;
	} e3rx_frm_s;

	typedef enum logic [2:0] {
		E3RX_IDLE = 3'b001,
		E3RX_INTEG = 3'b010,
		E3RX_LOST = 3'b100
	} e3rx_lof_e;

endpackage

// *** verilog/e3rx_ctrl_status.sv ***
// Purpose: receive E3 framer control, live/latched status and error counter
// Assumes: synchronous 16-bit host port; framer inputs on sys_clk
// Notes: latched flags are write-one-to-clear; an event beats a clear
`timescale 1ns/1ps
module e3rx_ctrl_status #(
	parameter int unsigned INTEG_3MS_CYC = e3rx_pkg::INTEG_3MS_CYC,
	parameter int unsigned INTEG_2MS_CYC = e3rx_pkg::INTEG_2MS_CYC,
	parameter int unsigned INTEG_1MS_CYC = e3rx_pkg::INTEG_1MS_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// host register port
	input wire logic cpu_cs,
	input wire logic cpu_we,
	input wire logic [7:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	output logic [15:0] cpu_rdata,
	output logic cpu_rvalid,
	// framer conditions and line pin
	input wire e3rx_pkg::e3rx_frm_s frm,
	input wire logic rx_signal_loss_in,
	// global and transmit context
	input wire logic port_irq_enable_field,
	input wire logic [1:0] tx_alarm_bit_source,
	// controls toward the data path
	output logic feac_data_bit,
	output logic downstream_alarm_insert,
	output logic tx_remote_alarm_req,
	output logic force_misframe,
	output logic rx_payload_enable_out,
	output logic frame_loss,
	output logic port_irq_req
);

	localparam int CW = e3rx_pkg::INTEG_CNT_W;

	// ------------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------------
	// saturating add; a wrapped count would hide a flood of errors
	function automatic logic [15:0] sat_add(input logic [15:0] c, input logic [3:0] n);
		logic [16:0] s;
		s = {1'b0, c} + {13'h0000, n};
		return s[16] ? 16'hffff : s[15:0];
	endfunction

	function automatic logic [CW-1:0] integ_limit(input logic [1:0] sel);
		case (sel)
			e3rx_pkg::INTEG_3MS: integ_limit = CW'(INTEG_3MS_CYC);
			e3rx_pkg::INTEG_2MS: integ_limit = CW'(INTEG_2MS_CYC);
			default: integ_limit = CW'(INTEG_1MS_CYC);
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	e3rx_pkg::e3rx_ctrl_s ctrl_reg;
	logic [15:0] irq_en1_reg;
	logic [15:0] irq_en2_reg;
	logic [15:0] change_reg;
	logic [15:0] error_reg;
	logic [15:0] count_reg;
	logic [15:0] live_prev_reg;
	logic realign_prev_reg;
	logic oof_prev_reg;
	logic count_nz_prev_reg;
	logic los_meta_reg;
	logic los_reg;
	e3rx_pkg::e3rx_lof_e lof_state_reg;
	logic [CW-1:0] integ_reg;
	logic [15:0] live_now;
	logic [15:0] count_status;
	logic [3:0] inc_amt;
	logic [3:0] bit_errs;
	logic count_allow;
	logic wr_en;
	logic rd_en;
	logic count_nz;

	assign wr_en = cpu_cs & cpu_we;
	assign rd_en = cpu_cs & ~cpu_we;

	// ------------------------------------------------------------------------
	// loss-of-signal pin synchroniser
	// ------------------------------------------------------------------------
	// pin is asynchronous to sys_clk; only los_reg is read by logic
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			los_meta_reg <= 1'b0;
			los_reg <= 1'b0;
		end else begin
			los_meta_reg <= rx_signal_loss_in;
			los_reg <= los_meta_reg;
		end
	end

	// ------------------------------------------------------------------------
	// control and enable registers
	// ------------------------------------------------------------------------
	// reserved control bits stay zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_reg <= e3rx_pkg::RST_CONTROL;
		end else if (wr_en && cpu_addr == e3rx_pkg::OFS_CONTROL) begin
			ctrl_reg <= cpu_wdata & e3rx_pkg::MASK_CONTROL;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_en1_reg <= e3rx_pkg::RST_IRQ_EN;
			irq_en2_reg <= e3rx_pkg::RST_IRQ_EN;
		end else if (wr_en) begin
			if (cpu_addr == e3rx_pkg::OFS_CHANGE_IRQ_EN) begin
				irq_en1_reg <= cpu_wdata & e3rx_pkg::MASK_CHANGE;
			end
			if (cpu_addr == e3rx_pkg::OFS_ERROR_IRQ_EN) begin
				irq_en2_reg <= cpu_wdata & e3rx_pkg::MASK_ERROR;
			end
		end
	end

	// ------------------------------------------------------------------------
	// frame loss integration
	// ------------------------------------------------------------------------
	// timed misframe integration
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lof_state_reg <= e3rx_pkg::E3RX_IDLE;
			integ_reg <= '0;
		end else begin
			case (lof_state_reg)
				e3rx_pkg::E3RX_IDLE: begin
					integ_reg <= CW'(1);
					if (frm.misframe) begin
						lof_state_reg <= e3rx_pkg::E3RX_INTEG;
					end
				end
				e3rx_pkg::E3RX_INTEG: begin
					integ_reg <= integ_reg + CW'(1);
					if (!frm.misframe) begin
						lof_state_reg <= e3rx_pkg::E3RX_IDLE;
					end else if (integ_reg >= integ_limit(ctrl_reg.frame_loss_integration_sel)) begin
						lof_state_reg <= e3rx_pkg::E3RX_LOST;
					end
				end
				e3rx_pkg::E3RX_LOST: begin
					if (!frm.misframe) begin
						lof_state_reg <= e3rx_pkg::E3RX_IDLE;
					end
				end
				default: lof_state_reg <= e3rx_pkg::E3RX_IDLE;
			endcase
		end
	end

	assign frame_loss = (lof_state_reg == e3rx_pkg::E3RX_LOST) |
		(frm.misframe & (ctrl_reg.frame_loss_integration_sel == e3rx_pkg::INTEG_NONE));

	// ------------------------------------------------------------------------
	// live status
	// ------------------------------------------------------------------------
	// live picture
	always_comb begin
		live_now = 16'h0000;
		live_now[8] = frm.unframed_all_ones;
		live_now[7] = frm.alarm_bit;
		live_now[6] = frm.national_bit;
		live_now[4] = frame_loss;
		live_now[3] = frm.remote_alarm;
		live_now[2] = frm.ones_alarm;
		live_now[1] = frm.misframe;
		live_now[0] = los_reg;
	end

	assign count_nz = count_reg != 16'h0000;
	assign count_status = {15'h0000, count_nz};

	// ------------------------------------------------------------------------
	// edge history
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			live_prev_reg <= 16'h0000;
			oof_prev_reg <= 1'b0;
			count_nz_prev_reg <= 1'b0;
			realign_prev_reg <= 1'b0;
		end else begin
			live_prev_reg <= live_now;
			oof_prev_reg <= frm.misframe;
			count_nz_prev_reg <= count_nz;
			realign_prev_reg <= ctrl_reg.force_realign;
		end
	end

	// ------------------------------------------------------------------------
	// latched change flags
	// ------------------------------------------------------------------------
	// set beats a same-cycle clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			change_reg <= e3rx_pkg::RST_LATCHED;
		end else begin
			change_reg <= ((change_reg &
				~((wr_en && cpu_addr == e3rx_pkg::OFS_CHANGE_LATCHED) ? cpu_wdata : 16'h0000))
				| ((live_now ^ live_prev_reg) & e3rx_pkg::MASK_CHANGE)
				| ((frm.align_load & frm.align_differs) ? 16'h0020 : 16'h0000))
				& e3rx_pkg::MASK_CHANGE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			error_reg <= e3rx_pkg::RST_LATCHED;
		end else begin
			error_reg <= ((error_reg &
				~((wr_en && cpu_addr == e3rx_pkg::OFS_ERROR_LATCHED) ? cpu_wdata : 16'h0000))
				| ((frm.fas_check && frm.fas_bit_errs != 4'h0) ? 16'h0100 : 16'h0000)
				| ((count_nz && !count_nz_prev_reg) ? 16'h0001 : 16'h0000))
				& e3rx_pkg::MASK_ERROR;
		end
	end

	// ------------------------------------------------------------------------
	// framing error counter
	// ------------------------------------------------------------------------
	assign bit_errs = (frm.fas_bit_errs > e3rx_pkg::FAS_MAX_BIT_ERRS) ?
		e3rx_pkg::FAS_MAX_BIT_ERRS : frm.fas_bit_errs;
	// suppressed during misframe or ones alarm unless error_count_control is set
	assign count_allow = ctrl_reg.error_count_control | ~(frm.misframe | frm.ones_alarm);

	always_comb begin
		inc_amt = 4'h0;
		case (ctrl_reg.frame_err_count_type)
			e3rx_pkg::CNT_OOF_EVENTS: inc_amt = (frm.misframe && !oof_prev_reg) ? 4'h1 : 4'h0;
			e3rx_pkg::CNT_FAS_BITS: inc_amt = (frm.fas_check && count_allow) ? bit_errs : 4'h0;
			e3rx_pkg::CNT_FAS_WORDS: begin
				inc_amt = (frm.fas_check && count_allow && bit_errs != 4'h0) ? 4'h1 : 4'h0;
			end
			default: inc_amt = 4'h0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			count_reg <= 16'h0000;
		end else begin
			count_reg <= sat_add(count_reg, inc_amt);
		end
	end

	// ------------------------------------------------------------------------
	// data path controls
	// ------------------------------------------------------------------------
	// feac, insertion, remote alarm and payload enable outputs are registered so the data path sees clean levels
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			feac_data_bit <= 1'b0;
			downstream_alarm_insert <= 1'b0;
			tx_remote_alarm_req <= 1'b0;
			rx_payload_enable_out <= 1'b0;
		end else begin
			feac_data_bit <= ctrl_reg.alarm_link_source_sel ? frm.alarm_bit : frm.national_bit;
			downstream_alarm_insert <= ctrl_reg.manual_downstream_alarm_insert |
				(~ctrl_reg.auto_downstream_alarm_disable &
				(los_reg | frm.misframe | frm.ones_alarm));
			tx_remote_alarm_req <= (tx_alarm_bit_source == e3rx_pkg::TX_ALARM_AUTO) &
				((ctrl_reg.remote_alarm_on_frame_loss_en & frame_loss) |
				(~ctrl_reg.remote_alarm_on_signal_loss_dis & los_reg) |
				(~ctrl_reg.remote_alarm_on_misframe_dis & frm.misframe) |
				(~ctrl_reg.remote_alarm_on_ones_alarm_dis & frm.ones_alarm));
			rx_payload_enable_out <= ~frm.overhead_pos | ctrl_reg.overhead_masking_disable;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			force_misframe <= 1'b0;
		end else begin
			force_misframe <= ctrl_reg.force_realign & ~realign_prev_reg;
		end
	end

	assign port_irq_req = port_irq_enable_field &
		(|(change_reg & irq_en1_reg) | |(error_reg & irq_en2_reg));

	// ------------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------------
	// unmapped or reserved offsets read as zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cpu_rdata <= 16'h0000;
			cpu_rvalid <= 1'b0;
		end else begin
			cpu_rvalid <= rd_en;
			if (rd_en) begin
				case (cpu_addr)
					e3rx_pkg::OFS_CONTROL: cpu_rdata <= ctrl_reg;
					e3rx_pkg::OFS_LIVE_STATUS: cpu_rdata <= live_now;
					e3rx_pkg::OFS_COUNT_STATUS: cpu_rdata <= count_status;
					e3rx_pkg::OFS_CHANGE_LATCHED: cpu_rdata <= change_reg;
					e3rx_pkg::OFS_ERROR_LATCHED: cpu_rdata <= error_reg;
					e3rx_pkg::OFS_CHANGE_IRQ_EN: cpu_rdata <= irq_en1_reg;
					e3rx_pkg::OFS_ERROR_IRQ_EN: cpu_rdata <= irq_en2_reg;
					e3rx_pkg::OFS_ERR_COUNT: cpu_rdata <= count_reg;
					default: cpu_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	feac_source_a: assert property (
		##1 feac_data_bit == $past(ctrl_reg.alarm_link_source_sel ? frm.alarm_bit : frm.national_bit)
	) else $error("feac bit source wrong");

	manual_ais_a: assert property (
		ctrl_reg.manual_downstream_alarm_insert |=> downstream_alarm_insert
	) else $error("manual insertion missing");

	auto_ais_a: assert property (
		(!ctrl_reg.manual_downstream_alarm_insert && !ctrl_reg.auto_downstream_alarm_disable
			&& (los_reg || frm.misframe || frm.ones_alarm)) |=> downstream_alarm_insert
	) else $error("auto insertion missing");

	count_gate_a: assert property (
		(!ctrl_reg.error_count_control && (frm.misframe || frm.ones_alarm)
			&& ctrl_reg.frame_err_count_type != e3rx_pkg::CNT_OOF_EVENTS)
			|=> count_reg == $past(count_reg)
	) else $error("counted while gated");

	word_count_a: assert property (
		(ctrl_reg.frame_err_count_type == e3rx_pkg::CNT_FAS_WORDS && count_allow
			&& frm.fas_check && frm.fas_bit_errs != 4'h0 && count_reg != 16'hffff)
			|=> count_reg == $past(count_reg) + 16'h0001
	) else $error("word count step wrong");

	rai_lof_a: assert property (
		(tx_alarm_bit_source == e3rx_pkg::TX_ALARM_AUTO
			&& ctrl_reg.remote_alarm_on_frame_loss_en && frame_loss) |=> tx_remote_alarm_req
	) else $error("remote alarm on frame loss missing");

	rai_src_a: assert property (
		(tx_alarm_bit_source != e3rx_pkg::TX_ALARM_AUTO) |=> !tx_remote_alarm_req
	) else $error("remote alarm outside auto source");

	ovh_mask_a: assert property (
		(frm.overhead_pos && !ctrl_reg.overhead_masking_disable) |=> !rx_payload_enable_out
	) else $error("overhead not masked");

	lof_delay_a: assert property (
		($rose(frm.misframe) && ctrl_reg.frame_loss_integration_sel != e3rx_pkg::INTEG_NONE)
			|-> !frame_loss ##1 !frame_loss
	) else $error("frame loss without integration");

	lof_now_a: assert property (
		(frm.misframe && ctrl_reg.frame_loss_integration_sel == e3rx_pkg::INTEG_NONE) |-> frame_loss
	) else $error("frame loss not immediate");

	resync_pulse_a: assert property (
		$rose(ctrl_reg.force_realign) |=> force_misframe ##1 !force_misframe
	) else $error("realign pulse wrong");

	change_set_a: assert property (
		(live_now[1] != live_prev_reg[1]) |=> change_reg[1]
	) else $error("misframe change not latched");

	count_rise_a: assert property (
		(!$past(count_nz) && count_nz) |=> error_reg[e3rx_pkg::BIT_COUNT_RISE]
	) else $error("count rise not latched");

	irq_gate_a: assert property (
		!port_irq_enable_field |-> !port_irq_req
	) else $error("interrupt without port enable");

	lof_cover_c: cover property ($rose(frame_loss));
	resync_cover_c: cover property ($rose(force_misframe));
	clear_cover_c: cover property ($fell(change_reg[0]));
	irq_cover_c: cover property ($rose(port_irq_req));

endmodule

// *** verif/e3_g751_rx_control_status_tb.sv ***
// Purpose: self-checking bench for the receive E3 control/status bank
// Assumes: strobe host port, one access per cycle, read data one cycle late
// Notes: integration counts shortened so frame loss timing stays short
`timescale 1ns/1ps
module e3_g751_rx_control_status_tb;
	// -------------------------------------------------------------------
	// stimulus and observed signals
	// -------------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic cpu_cs = 1'b0;
	logic cpu_we = 1'b0;
	logic [7:0] cpu_addr = 8'h00;
	logic [15:0] cpu_wdata = 16'h0000;
	logic [15:0] cpu_rdata;
	logic cpu_rvalid;
	e3rx_pkg::e3rx_frm_s frm = '0;
	logic los_in = 1'b0;
	logic port_en = 1'b0;
	logic [1:0] tx_src = 2'h0;
	logic feac, ais_ins, rai_req, frc_mis, pay_en, lof, irq;
	int error_cnt = 0;
	int comparisons = 0;
	int pulses;
	logic [15:0] d;
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	e3rx_ctrl_status #(.INTEG_3MS_CYC(30), .INTEG_2MS_CYC(20), .INTEG_1MS_CYC(10)) DUT (
		.sys_clk(sys_clk), .rstn(rstn), .cpu_cs(cpu_cs), .cpu_we(cpu_we),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .frm(frm), .rx_signal_loss_in(los_in),
		.port_irq_enable_field(port_en), .tx_alarm_bit_source(tx_src),
		.feac_data_bit(feac), .downstream_alarm_insert(ais_ins),
		.tx_remote_alarm_req(rai_req), .force_misframe(frc_mis),
		.rx_payload_enable_out(pay_en), .frame_loss(lof), .port_irq_req(irq));
	// -------------------------------------------------------------------
	// shared tasks
	// -------------------------------------------------------------------
	task automatic tally_and_finish();
		$display("comparisons=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		cpu_cs <= 1'b1;
		cpu_we <= 1'b1;
		cpu_addr <= a;
		cpu_wdata <= v;
		@(posedge sys_clk);
		cpu_cs <= 1'b0;
		cpu_we <= 1'b0;
	endtask
	// read waits for the valid pulse under a bound
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge sys_clk);
		cpu_cs <= 1'b1;
		cpu_we <= 1'b0;
		cpu_addr <= a;
		@(posedge sys_clk);
		cpu_cs <= 1'b0;
		#1;
		n = 0;
		while (cpu_rvalid !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 4) begin
			error_cnt++;
			tally_and_finish();
		end
		d = cpu_rdata;
	endtask
	task automatic settle();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	// -------------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------------
	// one frame check pulse carrying n bit errors, then settle
	task automatic fas(input logic [3:0] n);
		frm.fas_check <= 1'b1;
		frm.fas_bit_errs <= n;
		@(posedge sys_clk);
		frm.fas_check <= 1'b0;
		settle();
	endtask
	task automatic t_regs();
		rd(8'h20);
		chk(d, 16'h0000);
		rd(8'h2c);
		chk(d, 16'h0000);
		rd(8'h22);
		chk(d, 16'h0000);
		wr(8'h20, 16'hfffe);
		rd(8'h20);
		chk(d, 16'h3ffe);
		wr(8'h20, 16'h0000);
	endtask
	task automatic t_ais();
		wr(8'h20, 16'h1000);
		settle();
		chk(ais_ins, 1'b1);
		wr(8'h20, 16'h0000);
		settle();
		chk(ais_ins, 1'b0);
		frm.ones_alarm <= 1'b1;
		settle();
		chk(ais_ins, 1'b1);
		chk(rai_req, 1'b1);
		wr(8'h20, 16'h0810);
		settle();
		chk(ais_ins, 1'b0);
		chk(rai_req, 1'b0);
		frm.ones_alarm <= 1'b0;
		wr(8'h20, 16'h0000);
	endtask
	// link source, live bits and overhead marking
	task automatic t_feac();
		frm.alarm_bit <= 1'b1;
		frm.national_bit <= 1'b0;
		frm.remote_alarm <= 1'b1;
		frm.unframed_all_ones <= 1'b1;
		frm.overhead_pos <= 1'b1;
		settle();
		chk(feac, 1'b0);
		chk(pay_en, 1'b0);
		wr(8'h20, 16'h2008);
		settle();
		chk(feac, 1'b1);
		chk(pay_en, 1'b1);
		rd(8'h24);
		chk(d & 16'h00c0, 16'h0080);
		chk(d & 16'h0008, 16'h0008);
		chk(d & 16'h0100, 16'h0100);
		frm <= '0;
		wr(8'h20, 16'h0000);
	endtask
	// misframe toggle latches, then write one clears
	task automatic t_flags();
		wr(8'h28, 16'h01ff);
		wr(8'h2a, 16'h0101);
		rd(8'h28);
		chk(d, 16'h0000);
		wr(8'h20, 16'h0006);
		frm.misframe <= 1'b1;
		settle();
		chk(lof, 1'b1);
		chk(rai_req, 1'b1);
		rd(8'h24);
		chk(d & 16'h0012, 16'h0012);
		rd(8'h28);
		chk(d & 16'h0002, 16'h0002);
		wr(8'h28, 16'h0002);
		rd(8'h28);
		chk(d & 16'h0002, 16'h0000);
		frm.misframe <= 1'b0;
		settle();
		chk(lof, 1'b0);
		rd(8'h28);
		chk(d & 16'h0002, 16'h0002);
		wr(8'h20, 16'h0000);
	endtask
	// shortened 1 ms integration is ten cycles here
	task automatic t_lof();
		wr(8'h20, 16'h00a4);
		frm.misframe <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		chk(lof, 1'b0);
		chk(rai_req, 1'b0);
		settle();
		settle();
		settle();
		chk(lof, 1'b1);
		chk(rai_req, 1'b1);
		frm.misframe <= 1'b0;
		settle();
		chk(lof, 1'b0);
		wr(8'h20, 16'h0000);
	endtask
	// a held realign bit gives exactly one pulse
	task automatic t_realign();
		pulses = 0;
		wr(8'h20, 16'h0001);
		repeat (10) begin
			@(posedge sys_clk);
			#1;
			if (frc_mis === 1'b1) begin
				pulses++;
			end
		end
		chk(pulses[15:0], 16'h0001);
		wr(8'h20, 16'h0000);
	endtask
	// two misframe rises so far were counted as occurrences
	task automatic t_count();
		rd(8'h34);
		chk(d, 16'h0002);
		rd(8'h26);
		chk(d, 16'h0001);
		rd(8'h2a);
		chk(d, 16'h0001);
		wr(8'h2a, 16'h0101);
		wr(8'h20, 16'h0100);
		fas(4'hc);
		rd(8'h34);
		chk(d, 16'h000c);
		rd(8'h2a);
		chk(d, 16'h0100);
		frm.misframe <= 1'b1;
		fas(4'h2);
		rd(8'h34);
		chk(d, 16'h000c);
		wr(8'h20, 16'h0500);
		fas(4'h2);
		rd(8'h34);
		chk(d, 16'h000e);
		frm.misframe <= 1'b0;
		wr(8'h20, 16'h0200);
		fas(4'h3);
		rd(8'h34);
		chk(d, 16'h000f);
		wr(8'h28, 16'h01ff);
		frm.align_differs <= 1'b1;
		frm.align_load <= 1'b1;
		@(posedge sys_clk);
		frm.align_load <= 1'b0;
		rd(8'h28);
		chk(d & 16'h0020, 16'h0020);
		frm.align_differs <= 1'b0;
		wr(8'h20, 16'h0000);
	endtask
	task automatic t_los_irq();
		wr(8'h28, 16'h01ff);
		wr(8'h2c, 16'h0001);
		port_en <= 1'b1;
		los_in <= 1'b1;
		settle();
		rd(8'h24);
		chk(d & 16'h0001, 16'h0001);
		chk(irq, 1'b1);
		chk(rai_req, 1'b1);
		chk(ais_ins, 1'b1);
		wr(8'h2c, 16'h0000);
		#1;
		chk(irq, 1'b0);
		wr(8'h2c, 16'h0001);
		tx_src <= 2'h3;
		settle();
		chk(rai_req, 1'b0);
		tx_src <= 2'h0;
		wr(8'h20, 16'h0040);
		settle();
		chk(rai_req, 1'b0);
		port_en <= 1'b0;
		settle();
		chk(irq, 1'b0);
		los_in <= 1'b0;
		wr(8'h20, 16'h0000);
	endtask
	// -------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_ais();
		t_feac();
		t_flags();
		t_lof();
		t_realign();
		t_count();
		t_los_irq();
		tally_and_finish();
	end
endmodule
